/* css_cfg.svh */
// constants for the core clock source selector and its time base
// Function
// R1 - pin held low: timing comes from the on-chip oscillator.
// R2 - first high level seen on the clock pin adopts the external clock.
// R3 - external selection holds until reset; never returns to the internal oscillator.
// R4 - external clock stopping halts normal operation, chopper switching included.
// R5 - enabled short-to-ground detection keeps working without any clock.
// R6 - controller disables drivers, for example by enable input, before stopping clock.
// R7 - chopper, velocity and acceleration all time off the selected clock.
// R8 - nominal internal clock, velocity 10000: 780 microsteps in 100 ms.
// R9 - host calibrates: velocity mode, two timed position reads, then velocity zero.
// R10 - host scales velocities by velocity times interval over position difference.
// R11 - external clock up to 18 MHz only at 50% duty; 10-16 MHz advised. The bench clock (HALF 3, 4 ns) runs at about 41.7 MHz.
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

`define CSS_CLK_PERIOD_NS 4
`define CSS_NS_PER_S 1000000000
`define CSS_MS_PER_S 1000
`define CSS_ACC_FRAC 24
`define CSS_PHASE_W 32
`define CSS_REF_STEPS 780
`define CSS_REF_TIME_MS 100
`define CSS_REF_VEL 10000
`define CSS_LOSS_NS 1000
`define CSS_CHOP_TICKS 200
`define CSS_ACC_TICKS 256
`define CSS_VEL_W 23
`define CSS_ACCEL_W 16
`define CSS_POS_W 32
`define CSS_SYNC_W 3

`endif

/* css_clk_src.sv */
// external clock source model driving the clock pin
`timescale 1ns/1ps
`default_nettype none
module css_clk_src #(
  parameter int HALF = 3
) (
  input wire logic clk_sys,
  input wire logic run,
  output var logic clk_pin
);
  int cnt;
  initial begin
    clk_pin = 1'b0;
    cnt = 0;
  end
  always @(posedge clk_sys) begin
    if (!run) begin
      clk_pin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      clk_pin <= ~clk_pin; // equal halves, 50% duty
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* css_clock_select.sv */
// core clock source selector with time base, chopper phase and velocity ramp
`timescale 1ns/1ps
`default_nettype none
`include "css_cfg.svh"
module css_clock_select import css_pkg::*; #(
  parameter int VEL_W = `CSS_VEL_W,
  parameter int ACCEL_W = `CSS_ACCEL_W,
  parameter int POS_W = `CSS_POS_W,
  parameter int CHOP_TICKS = `CSS_CHOP_TICKS,
  parameter int ACC_TICKS = `CSS_ACC_TICKS
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_pin,
  input wire logic short_pin,
  input wire logic drv_en_pin,
  input wire logic short_det_en,
  input wire logic [VEL_W-1:0] velocity_limit,
  input wire logic [ACCEL_W-1:0] acceleration_limit,
  output logic ext_clk_sel,
  output logic ext_clk_lost,
  output logic core_run,
  output logic core_tick,
  output logic chop_phase,
  output logic driver_on,
  output logic short_flag,
  output logic [POS_W-1:0] current_position,
  output logic [VEL_W-1:0] current_velocity
);
  localparam int PW = `CSS_PHASE_W;
  localparam int FW = `CSS_ACC_FRAC;
  localparam logic [63:0] CLK_HZ = 64'(`CSS_NS_PER_S) / 64'(`CSS_CLK_PERIOD_NS);
  localparam logic [63:0] REF_STEPS_PER_S =
    64'(`CSS_REF_STEPS) * 64'(`CSS_MS_PER_S) / 64'(`CSS_REF_TIME_MS);
  // nominal oscillator rate that gives the reference step count
  localparam logic [63:0] INT_HZ = REF_STEPS_PER_S * (64'd1 << FW) / 64'(`CSS_REF_VEL);
  localparam logic [PW-1:0] INT_INC = PW'(INT_HZ * (64'd1 << PW) / CLK_HZ);
  // least silence before the external clock counts as stopped, rounded up
  localparam int LOSS_CYC_RAW = (`CSS_LOSS_NS + `CSS_CLK_PERIOD_NS - 1) / `CSS_CLK_PERIOD_NS;
  localparam int LOSS_CYC = (LOSS_CYC_RAW < 1) ? 1 : LOSS_CYC_RAW;
  localparam int LW = $clog2(LOSS_CYC + 1);
  localparam int CW = $clog2(CHOP_TICKS + 1);
  localparam int AW = $clog2(ACC_TICKS + 1);

  logic [`CSS_SYNC_W-1:0] pin_lvl;
  logic clk_lvl;
  logic short_lvl;
  logic drv_en_lvl;
  logic clk_lvl_d_r;
  logic ext_rise;
  css_state_e state_r;
  css_state_e state_nxt;
  logic [LW-1:0] loss_cnt_r;
  logic loss_hit;
  logic [PW-1:0] int_phase_r;
  logic int_carry;
  logic [PW:0] int_sum;
  logic tick_nxt;
  logic [CW-1:0] chop_cnt_r;
  logic [AW-1:0] acc_cnt_r;
  logic [FW-1:0] frac_r;
  logic [FW:0] frac_sum;
  logic [VEL_W-1:0] vel_diff;
  logic [VEL_W-1:0] accel_ext;

  css_sync #(
    .WIDTH(`CSS_SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .pin_in({drv_en_pin, short_pin, clk_pin}),
    .level(pin_lvl)
  );

  assign clk_lvl = pin_lvl[0];
  assign short_lvl = pin_lvl[1];
  assign drv_en_lvl = pin_lvl[2];
  assign ext_rise = clk_lvl & ~clk_lvl_d_r;
  assign loss_hit = (loss_cnt_r == LW'(LOSS_CYC - 1));

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      clk_lvl_d_r <= 1'b0;
    end else begin
      clk_lvl_d_r <= clk_lvl;
    end
  end

  // source selection
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CSS_ST_INT: begin
        if (clk_lvl) begin
          state_nxt = CSS_ST_EXT_RUN; // [R2]
        end
      end
      CSS_ST_EXT_RUN: begin
        if (!ext_rise && loss_hit) begin
          state_nxt = CSS_ST_EXT_LOST; // [R4]
        end
      end
      CSS_ST_EXT_LOST: begin
        // stays external: resumes only on a new rising edge on the pin
        if (ext_rise) begin
          state_nxt = CSS_ST_EXT_RUN; // [R3]
        end
      end
      default: begin
        state_nxt = CSS_ST_INT;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= CSS_ST_INT; // [R1]
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycles since the last external rising edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      loss_cnt_r <= '0;
    end else if (state_r == CSS_ST_INT || ext_rise) begin
      loss_cnt_r <= '0;
    end else if (!loss_hit) begin
      loss_cnt_r <= loss_cnt_r + LW'(1);
    end
  end

  // internal oscillator model: phase accumulator at the nominal rate
  assign int_sum = {1'b0, int_phase_r} + {1'b0, INT_INC};
  assign int_carry = int_sum[PW];

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_phase_r <= '0;
    end else if (state_r == CSS_ST_INT) begin
      int_phase_r <= int_sum[PW-1:0]; // [R1]
    end
  end

  always_comb begin
    tick_nxt = 1'b0;
    unique case (state_r)
      CSS_ST_INT: tick_nxt = int_carry; // [R1]
      CSS_ST_EXT_RUN: tick_nxt = ext_rise; // [R7]
      CSS_ST_EXT_LOST: tick_nxt = 1'b0; // [R4]
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      core_tick <= 1'b0;
      ext_clk_sel <= 1'b0;
      ext_clk_lost <= 1'b0;
      core_run <= 1'b0;
    end else begin
      core_tick <= tick_nxt;
      ext_clk_sel <= (state_nxt != CSS_ST_INT);
      ext_clk_lost <= (state_nxt == CSS_ST_EXT_LOST);
      core_run <= (state_nxt != CSS_ST_EXT_LOST); // [R4]
    end
  end

  // chopper phase counts core ticks, so it freezes when ticks stop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chop_cnt_r <= '0;
      chop_phase <= 1'b0;
    end else if (tick_nxt) begin
      if (chop_cnt_r == CW'(CHOP_TICKS - 1)) begin
        chop_cnt_r <= '0;
        chop_phase <= ~chop_phase; // [R7]
      end else begin
        chop_cnt_r <= chop_cnt_r + CW'(1);
      end
    end
  end

  // short detection runs on the system clock, whatever the core clock does
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      short_flag <= 1'b0;
    end else if (short_det_en && short_lvl) begin
      short_flag <= 1'b1; // [R5]
    end
  end

  // drivers switch off with the core clock gone or a short seen
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      driver_on <= 1'b0;
    end else begin
      driver_on <= drv_en_lvl && (state_nxt != CSS_ST_EXT_LOST) &&
                   !short_flag && !(short_det_en && short_lvl); // [R4] [R5]
    end
  end

  // velocity ramps toward the limit once every ACC_TICKS core ticks
  // the size cast pads or trims the step to the velocity width, whichever the widths need
  assign accel_ext = VEL_W'(acceleration_limit);
  assign vel_diff = (velocity_limit > current_velocity) ?
                    velocity_limit - current_velocity : current_velocity - velocity_limit;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      acc_cnt_r <= '0;
      current_velocity <= '0;
    end else if (tick_nxt) begin
      if (acc_cnt_r == AW'(ACC_TICKS - 1)) begin
        acc_cnt_r <= '0;
        if (vel_diff <= accel_ext) begin
          current_velocity <= velocity_limit; // [R7]
        end else if (velocity_limit > current_velocity) begin
          current_velocity <= current_velocity + accel_ext;
        end else begin
          current_velocity <= current_velocity - accel_ext;
        end
      end else begin
        acc_cnt_r <= acc_cnt_r + AW'(1);
      end
    end
  end

  // position: velocity added to a fraction each tick, carry is one microstep
  assign frac_sum = {1'b0, frac_r} + (FW+1)'(current_velocity);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frac_r <= '0;
      current_position <= '0;
    end else if (tick_nxt) begin
      frac_r <= frac_sum[FW-1:0];
      if (frac_sum[FW]) begin
        current_position <= current_position + POS_W'(1); // [R8]
      end
    end
  end
endmodule
`default_nettype wire

/* css_clock_select_chk.sv */
// assertion checker for the clock source selector
`timescale 1ns/1ps
`default_nettype none
module css_clock_select_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic clk_pin,
  input wire logic short_pin,
  input wire logic short_det_en,
  input wire logic ext_clk_sel,
  input wire logic ext_clk_lost,
  input wire logic core_run,
  input wire logic core_tick,
  input wire logic driver_on,
  input wire logic short_flag
);
  int rise_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // cycles since the last rising edge on the pin
  always_ff @(posedge clk_sys) begin
    if (srst || $rose(clk_pin)) begin
      rise_cnt <= 0;
    end else if (rise_cnt < 999) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  property p_sel_cause;
    $rose(ext_clk_sel) |-> $past(clk_pin, 3) || $past(clk_pin, 4) || $past(clk_pin, 5);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select without pin high");
  property p_sel_soon;
    $rose(clk_pin) && !ext_clk_sel |-> ##[3:8] ext_clk_sel;
  endproperty
  a_sel_soon: assert property (p_sel_soon) else $error("select too late");
  property p_sticky;
    ext_clk_sel |=> ext_clk_sel;
  endproperty
  a_sticky: assert property (p_sticky) else $error("select dropped");
  property p_int_run;
    !ext_clk_sel && !$past(srst) |-> core_run;
  endproperty
  a_int_run: assert property (p_int_run) else $error("internal base not running");
  property p_lost_off;
    ext_clk_lost |-> ext_clk_sel && !core_run && !driver_on;
  endproperty
  a_lost_off: assert property (p_lost_off) else $error("running without clock");
  property p_lost_late;
    $rose(ext_clk_lost) |-> rise_cnt >= 240;
  endproperty
  a_lost_late: assert property (p_lost_late) else $error("loss flagged early");
  property p_lost_due;
    ext_clk_sel && rise_cnt == 270 |-> ext_clk_lost;
  endproperty
  a_lost_due: assert property (p_lost_due) else $error("loss not flagged");
  property p_ext_tick;
    ext_clk_sel && core_tick |-> rise_cnt <= 8;
  endproperty
  a_ext_tick: assert property (p_ext_tick) else $error("tick not from pin");
  property p_short;
    (short_det_en && short_pin) [*6] |-> ##[0:2] short_flag;
  endproperty
  a_short: assert property (p_short) else $error("short not flagged");
endmodule
bind css_clock_select css_clock_select_chk u_chk (.clk_sys(clk_sys), .srst(srst),
  .clk_pin(clk_pin), .short_pin(short_pin), .short_det_en(short_det_en),
  .ext_clk_sel(ext_clk_sel), .ext_clk_lost(ext_clk_lost), .core_run(core_run),
  .core_tick(core_tick), .driver_on(driver_on), .short_flag(short_flag));
`default_nettype wire

/* css_pkg.sv */
// types shared by the clock source selector
`default_nettype none
package css_pkg;
  typedef enum logic [2:0] {
    CSS_ST_INT = 3'b001,
    CSS_ST_EXT_RUN = 3'b010,
    CSS_ST_EXT_LOST = 3'b100
  } css_state_e;
endpackage
`default_nettype wire

/* css_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module css_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit changes only once the second and third stage agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      level <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          level[i] <= s3_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb_clock_source_select.sv */
// self-checking bench for the clock source selector
`timescale 1ns/1ps
`default_nettype none
module tb_clock_source_select;
  logic clk_sys, srst, clk_pin, short_pin, drv_en_pin, short_det_en, run;
  logic [22:0] velocity_limit, current_velocity;
  logic [15:0] acceleration_limit;
  logic ext_clk_sel, ext_clk_lost, core_run, core_tick, chop_phase, driver_on, short_flag;
  logic [31:0] current_position;
  int n_mismatch = 0;
  int check_count = 0;
  css_clock_select #(.ACC_TICKS(4), .CHOP_TICKS(4)) dut (.clk_sys(clk_sys), .srst(srst),
    .clk_pin(clk_pin), .short_pin(short_pin), .drv_en_pin(drv_en_pin),
    .short_det_en(short_det_en), .velocity_limit(velocity_limit),
    .acceleration_limit(acceleration_limit), .ext_clk_sel(ext_clk_sel),
    .ext_clk_lost(ext_clk_lost), .core_run(core_run), .core_tick(core_tick),
    .chop_phase(chop_phase), .driver_on(driver_on), .short_flag(short_flag),
    .current_position(current_position), .current_velocity(current_velocity));
  css_clk_src #(.HALF(3)) src (.clk_sys(clk_sys), .run(run), .clk_pin(clk_pin));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task chk(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t %s", $time, what);
    end
  endtask
  task chk_rng(input logic [31:0] got, input int lo, input int hi, input string what);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      n_mismatch++;
      $display("Error t=%0t %s got %0d", $time, what, got);
    end
  endtask
  task end_sim;
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task t_internal;
    logic [31:0] p1;
    chk(ext_clk_sel, 1'b0, "sel");
    chk(core_run, 1'b1, "run");
    velocity_limit = 23'd8000000;
    acceleration_limit = 16'hffff;
    step(12000);
    chk_rng(current_velocity, 8000000, 8000000, "vel");
    p1 = current_position;
    step(40000);
    chk_rng(current_position - p1, 990, 1007, "steps");
    // host factor times 1000: velocity 8000000 over 160 us, divided by the steps
    chk_rng(32'd1280000 / (current_position - p1), 1271, 1293, "factor");
    velocity_limit = 23'd0; // calibration run ends
  endtask
  task t_adopt;
    int ticks, flips;
    logic last;
    run = 1'b1;
    step(12);
    chk(ext_clk_sel, 1'b1, "adopt");
    ticks = 0;
    flips = 0;
    last = chop_phase;
    repeat (300) begin
      step(1);
      if (core_tick === 1'b1) ticks++;
      if (chop_phase !== last) flips++;
      last = chop_phase;
    end
    chk_rng(ticks, 49, 51, "ticks");
    chk_rng(flips, 11, 14, "chop");
  endtask
  task t_lost;
    drv_en_pin = 1'b0; // drivers off before the clock stops
    step(2);
    run = 1'b0;
    step(270);
    chk(ext_clk_lost, 1'b1, "lost");
    chk(core_run, 1'b0, "halt");
    chk(ext_clk_sel, 1'b1, "stay");
    short_det_en = 1'b1;
    short_pin = 1'b1;
    step(8);
    chk(short_flag, 1'b1, "short");
    run = 1'b1;
    short_pin = 1'b0;
    drv_en_pin = 1'b1;
    step(12);
    chk(ext_clk_lost, 1'b0, "resume");
    chk(driver_on, 1'b0, "blocked");
  endtask
  task t_reset;
    run = 1'b0;
    srst = 1'b1;
    step(2);
    srst = 1'b0;
    step(20);
    chk(ext_clk_sel, 1'b0, "reinit");
    chk(core_run, 1'b1, "intrun");
    chk(short_flag, 1'b0, "clr");
  endtask
  // the scenarios take about 53000 cycles; this leaves a margin of about two fifths
  initial begin
    #300000;
    n_mismatch++;
    end_sim;
  end
  initial begin
    srst = 1'b1;
    run = 1'b0;
    short_pin = 1'b0;
    drv_en_pin = 1'b1;
    short_det_en = 1'b0;
    velocity_limit = 23'd0;
    acceleration_limit = 16'h0000;
    step(2);
    srst = 1'b0;
    step(2);
    t_internal;
    t_adopt;
    t_lost;
    t_reset;
    end_sim;
  end
endmodule
`default_nettype wire
